//--- logic/lmp_regs.svh
`ifndef LMP_REGS_SVH
`define LMP_REGS_SVH
`define LMP_DATA_W 8
`define LMP_SEL_DATA 1'b1
`define LMP_SEL_CMD 1'b0
`define LMP_RW_READ 1'b1
`define LMP_RW_WRITE 1'b0
`define LMP_PROTO_8080 1'b0
`define LMP_PROTO_6800 1'b1
`define LMP_STROBE_HOLD 8'h02
`define LMP_FRAME_DIV 16'h0100
`define LMP_CLK_DIV 8'h04
`endif

//--- logic/lmp_pkg.sv
package lmp_pkg;
  typedef logic [7:0] lmp_byte_t;
  typedef enum logic [1:0] {
    LMP_IDLE,
    LMP_SETUP,
    LMP_STROBE,
    LMP_HOLD
  } lmp_host_state_t;
endpackage

//--- logic/lmp_bus_if.sv
`timescale 1ns/1ns
interface lmp_bus_if;
  logic select_a_n;
  logic select_b;
  logic data_cmd_sel;
  logic wr_pin;
  logic rd_pin;
  logic [7:0] host_data;
  logic host_data_oe_n;
  logic [7:0] dev_data;
  logic dev_data_oe_n;
  logic reset_n;
  modport dev (
    input select_a_n, select_b, data_cmd_sel, wr_pin, rd_pin, host_data, host_data_oe_n,
    input reset_n,
    output dev_data, dev_data_oe_n
  );
  modport host (
    output select_a_n, select_b, data_cmd_sel, wr_pin, rd_pin, host_data, host_data_oe_n,
    output reset_n,
    input dev_data, dev_data_oe_n
  );
endinterface

//--- logic/lmp_device.sv
`timescale 1ns/1ns
`include "lmp_regs.svh"
// Functional notes
// - transfers only when select_a_n low, select_b high
// - data_cmd_sel high data, low command
// - 8080 write captured at write strobe rise
// - 8080 drive bus only while read low; the registered enable lags read by one cycle at both edges
// - 6800 write pin is read/write direction
// - 6800 read pin is active-high enable
// - reset_n low level initialises all settings
// - display clock out when master and source high
// - provide liquid-crystal alternation output
// - provide active-low blanking output
module lmp_device #(
  parameter int DATA_W = `LMP_DATA_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  lmp_bus_if.dev bus,
  input wire logic proto_sel_in,
  input wire logic master_sel_in,
  input wire logic clock_source_sel_in,
  input wire logic display_clock_pin_in,
  input wire logic blank_req_in,
  input wire logic [7:0] read_data_in,
  output logic [7:0] wr_data_out,
  output logic wr_is_data_out,
  output logic wr_valid_out,
  output logic rd_is_data_out,
  output logic rd_taken_out,
  output logic display_clock_pin_out,
  output logic display_clock_pin_oe_n_out,
  output logic lc_alternation_out,
  output logic blanking_n_out
);
  // the pin map is fixed at one byte; other widths cannot be served
  if (DATA_W != 8) begin : g_bad_width
    $error("lmp_device: data width must be 8");
  end

  typedef struct packed {
    logic wr_q;
    logic rd_q;
    logic [7:0] wr_data;
    logic wr_is_data;
    logic wr_valid;
    logic rd_is_data;
    logic rd_taken;
    logic [7:0] dout;
    logic dout_oe_n;
    logic [7:0] clk_div;
    logic clk_q;
    logic ext_clk_q;
    logic [15:0] frame_cnt;
    logic alt;
    logic blank_n;
    logic clk_oe_n;
  } lmp_dev_state_t;

  lmp_dev_state_t s, next_s;
  logic selected, wr_cycle, rd_active, tick;

  always_comb begin
    next_s = s;
    selected = !bus.select_a_n && bus.select_b;
    next_s.wr_q = bus.wr_pin;
    next_s.rd_q = bus.rd_pin;
    next_s.wr_valid = 1'b0;
    next_s.rd_taken = 1'b0;
    wr_cycle = 1'b0;
    rd_active = 1'b0;
    if (proto_sel_in == `LMP_PROTO_8080) begin
      wr_cycle = selected && !s.wr_q && bus.wr_pin;
      rd_active = selected && !bus.rd_pin;
      if (selected && s.rd_q && !bus.rd_pin) next_s.rd_taken = 1'b1;
    end else begin
      // data latched as enable falls, the 6800 write point
      wr_cycle = selected && s.rd_q && !bus.rd_pin && bus.wr_pin == `LMP_RW_WRITE;
      rd_active = selected && bus.rd_pin && bus.wr_pin == `LMP_RW_READ;
      if (selected && !s.rd_q && bus.rd_pin && bus.wr_pin == `LMP_RW_READ) begin
        next_s.rd_taken = 1'b1;
      end
    end
    if (wr_cycle) begin
      next_s.wr_data = bus.host_data;
      next_s.wr_is_data = bus.data_cmd_sel == `LMP_SEL_DATA;
      next_s.wr_valid = 1'b1;
    end
    if (next_s.rd_taken) next_s.rd_is_data = bus.data_cmd_sel == `LMP_SEL_DATA;
    next_s.dout = read_data_in;
    next_s.dout_oe_n = !rd_active;
    // display clock: own divider when master and internal source
    next_s.clk_oe_n = !(master_sel_in && clock_source_sel_in);
    next_s.ext_clk_q = display_clock_pin_in;
    tick = 1'b0;
    if (!next_s.clk_oe_n) begin
      if (s.clk_div == `LMP_CLK_DIV - 8'h01) begin
        next_s.clk_div = 8'h00;
        next_s.clk_q = !s.clk_q;
        tick = !s.clk_q;
      end else begin
        next_s.clk_div = s.clk_div + 8'h01;
      end
    end else begin
      next_s.clk_div = 8'h00;
      next_s.clk_q = 1'b0;
      tick = display_clock_pin_in && !s.ext_clk_q;
    end
    if (tick) begin
      if (s.frame_cnt == `LMP_FRAME_DIV - 16'h0001) begin
        next_s.frame_cnt = 16'h0000;
        next_s.alt = !s.alt;
      end else begin
        next_s.frame_cnt = s.frame_cnt + 16'h0001;
      end
    end
    next_s.blank_n = !blank_req_in;
    // level reset: held state stays initialised while reset_n is low
    if (!bus.reset_n) begin
      next_s = '0;
      next_s.dout_oe_n = 1'b1;
      next_s.clk_oe_n = 1'b1;
      next_s.wr_q = 1'b1;
      next_s.rd_q = bus.rd_pin;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.wr_q <= 1'b1;
      s.dout_oe_n <= 1'b1;
      s.clk_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.dev_data = s.dout;
  assign bus.dev_data_oe_n = s.dout_oe_n;
  assign wr_data_out = s.wr_data;
  assign wr_is_data_out = s.wr_is_data;
  assign wr_valid_out = s.wr_valid;
  assign rd_is_data_out = s.rd_is_data;
  assign rd_taken_out = s.rd_taken;
  assign display_clock_pin_out = s.clk_q;
  assign display_clock_pin_oe_n_out = s.clk_oe_n;
  assign lc_alternation_out = s.alt;
  assign blanking_n_out = s.blank_n;
endmodule

//--- logic/lmp_host.sv
`timescale 1ns/1ns
`include "lmp_regs.svh"
module lmp_host (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  lmp_bus_if.host bus,
  input wire logic proto_sel_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_is_data_in,
  input wire logic [7:0] req_data_in,
  input wire logic dev_reset_in,
  output logic req_ready_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_valid_out
);
  typedef struct packed {
    lmp_pkg::lmp_host_state_t st;
    logic [7:0] cnt;
    logic write;
    logic cs;
    logic a0;
    logic wr;
    logic rd;
    lmp_pkg::lmp_byte_t dout;
    logic oe_n;
    logic ready;
    lmp_pkg::lmp_byte_t rsp;
    logic rsp_v;
    logic rst_n;
  } lmp_host_reg_t;

  lmp_host_reg_t s, next_s;
  logic p6800;

  always_comb begin
    next_s = s;
    p6800 = proto_sel_in == `LMP_PROTO_6800;
    next_s.rsp_v = 1'b0;
    next_s.rst_n = !dev_reset_in;
    next_s.cnt = s.cnt + 8'h01;
    unique case (s.st)
      lmp_pkg::LMP_IDLE: begin
        next_s.ready = 1'b1;
        // idle strobe level differs per protocol: enable low, read strobe high
        next_s.rd = !p6800;
        if (req_valid_in && s.ready) begin
          next_s.ready = 1'b0;
          next_s.write = req_write_in;
          next_s.cs = 1'b1;
          next_s.a0 = req_is_data_in;
          next_s.dout = req_data_in;
          next_s.oe_n = !req_write_in;
          next_s.wr = p6800 ? (req_write_in ? `LMP_RW_WRITE : `LMP_RW_READ) : 1'b1;
          next_s.cnt = 8'h00;
          next_s.st = lmp_pkg::LMP_SETUP;
        end
      end
      lmp_pkg::LMP_SETUP: begin
        if (p6800) next_s.rd = 1'b1;
        else if (s.write) next_s.wr = 1'b0;
        else next_s.rd = 1'b0;
        next_s.cnt = 8'h00;
        next_s.st = lmp_pkg::LMP_STROBE;
      end
      lmp_pkg::LMP_STROBE: begin
        if (s.cnt == `LMP_STROBE_HOLD) begin
          if (!s.write) begin
            next_s.rsp = bus.dev_data;
            next_s.rsp_v = 1'b1;
          end
          next_s.rd = !p6800;
          if (s.write && !p6800) next_s.wr = 1'b1;
          next_s.cnt = 8'h00;
          next_s.st = lmp_pkg::LMP_HOLD;
        end
      end
      lmp_pkg::LMP_HOLD: begin
        next_s.cs = 1'b0;
        next_s.oe_n = 1'b1;
        next_s.wr = 1'b1;
        next_s.st = lmp_pkg::LMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.st <= lmp_pkg::LMP_IDLE;
      s.wr <= 1'b1;
      s.rd <= 1'b1;
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.select_a_n = !s.cs;
  assign bus.select_b = s.cs;
  assign bus.data_cmd_sel = s.a0;
  assign bus.wr_pin = s.wr;
  assign bus.rd_pin = s.rd;
  assign bus.host_data = s.dout;
  assign bus.host_data_oe_n = s.oe_n;
  assign bus.reset_n = s.rst_n;
  assign req_ready_out = s.ready;
  assign rsp_data_out = s.rsp;
  assign rsp_valid_out = s.rsp_v;
endmodule

//--- sim/lmp_asserts.sv
`timescale 1ns/1ns
module lmp_asserts (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic proto_sel_in,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic data_cmd_sel,
  input wire logic wr_pin,
  input wire logic rd_pin,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic reset_n
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic sel = !select_a_n && select_b;
  sequence s_wr_low;
    (!wr_pin && sel)[*2];
  endsequence
  sequence s_wr_end;
    wr_pin && sel;
  endsequence
  a_drive_when_sel: assert property (!dev_data_oe_n |-> sel)
    else $error("device drives while deselected");
  a_cmd_sel_hold: assert property (sel && $past(sel) |-> $stable(data_cmd_sel))
    else $error("data/command select moved in cycle");
  a_wr_strobe_pulse: assert property (!proto_sel_in && sel && $fell(wr_pin) |->
    s_wr_low ##[1:16] s_wr_end)
    else $error("write strobe malformed");
  a_rd_drive_only: assert property (!proto_sel_in && !dev_data_oe_n |->
    !rd_pin || $past(!rd_pin))
    else $error("device drives without read strobe");
  a_rd_drive_start: assert property (!proto_sel_in && sel && $fell(rd_pin) |=>
    !dev_data_oe_n)
    else $error("device late on read");
  a_dir_write: assert property (proto_sel_in && sel && rd_pin && !wr_pin |->
    dev_data_oe_n && !host_data_oe_n)
    else $error("write direction not honoured");
  a_enable_read: assert property (proto_sel_in && sel && wr_pin && $rose(rd_pin) |=>
    !dev_data_oe_n)
    else $error("enable did not start read");
  a_level_reset: assert property (!reset_n |=> dev_data_oe_n)
    else $error("bus held during reset");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_in = 0, rst_in = 1, proto = 0, rq_v = 0, rq_w = 0, rq_d = 0, dev_rst = 0;
  logic ms = 0, src = 0, ext_ck = 0, blank = 0, rdy, rsp_v, wr_d, wr_v, rd_d, ck_o, ck_oe_n;
  logic lc_alt, blank_n, rd_tk;
  int n_taken = 0, n_reads = 0;
  logic [7:0] rq_data = 8'h00, rd_data = 8'h00, rsp, wr_data, seed = 8'h16;
  int n_mismatch = 0, num_checks = 0, k;
  // shared clock pin: device drives it only when its enable is low
  wire logic dclk = ck_oe_n ? ext_ck : ck_o;
  lmp_bus_if bus_if ();
  always #20 sys_clk_in = !sys_clk_in;
  always @(negedge sys_clk_in) ext_ck <= !ext_ck;
  // sampled on the falling edge so each one-cycle pulse is counted once
  always @(negedge sys_clk_in) if (rd_tk === 1'b1) n_taken++;
  lmp_host u_lmp_host (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_if.host),
    .proto_sel_in(proto), .req_valid_in(rq_v), .req_write_in(rq_w), .req_is_data_in(rq_d),
    .req_data_in(rq_data), .dev_reset_in(dev_rst), .req_ready_out(rdy),
    .rsp_data_out(rsp), .rsp_valid_out(rsp_v));
  lmp_device u_lmp_device (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus(bus_if.dev),
    .proto_sel_in(proto), .master_sel_in(ms), .clock_source_sel_in(src),
    .display_clock_pin_in(dclk), .blank_req_in(blank), .read_data_in(rd_data),
    .wr_data_out(wr_data), .wr_is_data_out(wr_d), .wr_valid_out(wr_v),
    .rd_is_data_out(rd_d), .rd_taken_out(rd_tk), .display_clock_pin_out(ck_o),
    .display_clock_pin_oe_n_out(ck_oe_n), .lc_alternation_out(lc_alt),
    .blanking_n_out(blank_n));
  lmp_asserts u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .proto_sel_in(proto),
    .select_a_n(bus_if.select_a_n), .select_b(bus_if.select_b),
    .data_cmd_sel(bus_if.data_cmd_sel), .wr_pin(bus_if.wr_pin), .rd_pin(bus_if.rd_pin),
    .host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
    .reset_n(bus_if.reset_n));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] exp_oe_n(input logic m, input logic c);
    return {7'h00, !(m && c)};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic settle(input logic ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // entered at a falling edge; ready seen there means the next rise takes it
  task automatic xfer(input logic w, input logic d, input logic [7:0] v);
    int n;
    rq_w = w;
    rq_d = d;
    rq_data = v;
    rd_data = ~v;
    if (!w) n_reads++;
    for (n = 0; n < 40 && rdy !== 1'b1; n++) @(negedge sys_clk_in);
    settle(rdy === 1'b1);
    rq_v = 1;
    @(negedge sys_clk_in);
    rq_v = 0;
    for (n = 0; n < 40 && (w ? wr_v : rsp_v) !== 1'b1; n++) @(negedge sys_clk_in);
    settle((w ? wr_v : rsp_v) === 1'b1);
    chk(w ? wr_data : rsp, w ? v : ~v);
    chk({7'h00, w ? wr_d : rd_d}, {7'h00, d});
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 0;
    for (k = 0; k < 2; k++) begin
      blank = !k[0];
      repeat (3) @(negedge sys_clk_in);
      chk({7'h00, blank_n}, {7'h00, k[0]});
    end
    for (k = 0; k < 3; k++) begin
      ms = k == 2;
      src = k != 0;
      repeat (3) @(negedge sys_clk_in);
      chk({7'h00, ck_oe_n}, exp_oe_n(ms, src));
    end
    for (k = 0; k < 3000 && lc_alt !== 1'b1; k++) @(negedge sys_clk_in);
    chk({7'h00, lc_alt}, 8'h01);
    dev_rst = 1;
    @(negedge sys_clk_in);
    dev_rst = 0;
    repeat (3) @(negedge sys_clk_in);
    chk({7'h00, lc_alt}, 8'h00);
    $display("pin tests done");
    // corner bytes first, then random mix of reads and writes per protocol
    for (k = 0; k < 24; k++) begin
      proto = k >= 12;
      seed = (k % 12 < 2) ? {8{k[0]}} : lfsr(seed);
      xfer(seed[0], seed[1], seed);
    end
    $display("bus tests done");
    chk(n_taken[7:0], n_reads[7:0]);
    wrap_up();
  end
endmodule
